// file: drcam_chk.sv
/*
 Port checker for drcam_top.
 Assumes it is bound into drcam_top and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module drcam_chk (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic cfg_done_i,
    input wire logic [3:0] row_populated_i,
    input wire logic [7:0] row_density_i,
    input wire logic [3:0] row_x16_i,
    input wire logic [1:0] sw_force_throttle_i,
    input wire logic [63:0] rd_throttle_ctrl_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic req_auto_precharge_i,
    input wire logic [31:0] req_addr_i,
    input wire logic req_ready_o,
    input wire logic cmd_ready_i,
    input wire logic cmd_valid_o,
    input wire logic [3:0] cmd_row_cs_o,
    input wire logic [1:0] cmd_bank_o,
    input wire logic [12:0] cmd_row_addr_o,
    input wire logic [12:0] cmd_col_addr_o,
    input wire logic addr_error_o,
    input wire logic config_error_o,
    input wire logic rd_throttled_o,
    input wire logic wr_throttled_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_take;
        req_valid_i && req_ready_o;
    endsequence
    sequence s_take_row0;
        s_take ##0 (row_populated_i == 4'h1 && row_density_i[1:0] == 2'h0 && row_x16_i[0]
            && req_addr_i[31:26] == 6'h00);
    endsequence
    chk_cfg_blocks: assert property (!cfg_done_i |-> !req_ready_o)
        else $error("request accepted before configuration");
    chk_take_answer: assert property (s_take |=> cmd_valid_o || addr_error_o)
        else $error("taken request gave no answer");
    chk_small_map: assert property (s_take_row0 |=> cmd_bank_o == {$past(req_addr_i[18]),
        $past(req_addr_i[13])} && cmd_row_addr_o[0] == $past(req_addr_i[17])
        && cmd_col_addr_o[0] == $past(req_addr_i[4])) else $error("bank or address bit wrong");
    chk_ap_col: assert property (s_take ##1 cmd_valid_o |->
        cmd_col_addr_o[10] == $past(req_auto_precharge_i)) else $error("precharge bit wrong");
    chk_cmd_hold: assert property (cmd_valid_o && !cmd_ready_i |=> cmd_valid_o
        && $stable(cmd_row_addr_o) && $stable(cmd_col_addr_o)) else $error("command dropped");
    chk_cs_onehot: assert property (cmd_valid_o |-> $onehot(cmd_row_cs_o))
        else $error("row select not one-hot");
    chk_force_thr: assert property (|sw_force_throttle_i |->
        ({wr_throttled_o, rd_throttled_o} & sw_force_throttle_i) == sw_force_throttle_i)
        else $error("forced throttle not shown");
    chk_rd_refused: assert property (rd_throttled_o && rd_throttle_ctrl_i[47:32] == 16'h0000
        && !req_write_i |-> !req_ready_o) else $error("throttled read accepted");
    chk_x16_odd: assert property (|(row_populated_i & row_x16_i & 4'hA) |-> config_error_o)
        else $error("double sided x16 not flagged");
    chk_bad_density: assert property (row_populated_i[0] && row_density_i[1:0] == 2'h3
        |-> config_error_o) else $error("bad density not flagged");
endmodule
bind drcam_top drcam_chk drcam_chk_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .cfg_done_i(cfg_done_i), .row_populated_i(row_populated_i), .row_density_i(row_density_i),
    .row_x16_i(row_x16_i), .sw_force_throttle_i(sw_force_throttle_i),
    .rd_throttle_ctrl_i(rd_throttle_ctrl_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_auto_precharge_i(req_auto_precharge_i),
    .req_addr_i(req_addr_i), .req_ready_o(req_ready_o), .cmd_ready_i(cmd_ready_i),
    .cmd_valid_o(cmd_valid_o), .cmd_row_cs_o(cmd_row_cs_o), .cmd_bank_o(cmd_bank_o),
    .cmd_row_addr_o(cmd_row_addr_o), .cmd_col_addr_o(cmd_col_addr_o),
    .addr_error_o(addr_error_o), .config_error_o(config_error_o),
    .rd_throttled_o(rd_throttled_o), .wr_throttled_o(wr_throttled_o));
`default_nettype wire

// file: drcam_cmd_sink.sv
/*
 Command consumer model at the memory side of drcam_top.
 Assumes one clock; slow_i makes it stall at random.
*/
`timescale 1ns/100ps
`default_nettype none
module drcam_cmd_sink (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o
);
    logic [7:0] lfsr_reg;
    // Stalls come from a free running sequence so they hit odd cycles.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lfsr_reg <= 8'h5A;
            cmd_ready_o <= 1'b0;
        end else begin
            lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
            cmd_ready_o <= !slow_i || (lfsr_reg[0] && cmd_valid_i);
        end
    end
endmodule
`default_nettype wire

// file: drcam_pkg.sv
/*
 Constants, mapping tables and control field layout for the DDR row
 configuration and host address map block.
 Assumes one 50 MHz clock and a 32-bit byte host address.
*/
// Function
// RULE1 - Dual discrete dynamic 12x9x2: BA1=18, BA0=13
// RULE2 - At most four rows, one chip select each
// RULE3 - x8/x16, 128/256/512 Mb, 64-bit DIMMs
// RULE4 - JEDEC only; x16 DIMMs single sided
// RULE5 - No hardware size or type detection
// RULE6 - Software configures before any memory cycle
// RULE7 - Presence ROM address is 1010 plus strap
// RULE8 - Software reads presence bytes 2,3,4,5,11,12,17
// RULE9 - Reduce accesses above thermal threshold
// RULE10 - Read and write throttles independent, 64-bit control
// RULE11 - Throttle on software force or counter
// RULE12 - Translation follows targeted row configuration
`default_nettype none
package drcam_pkg;
    localparam int NUM_ROWS = 4;
    localparam int ADDR_W = 32;
    localparam int DRAM_A_W = 13;
    localparam int CFG_NUM = 6;
    typedef logic [4:0] drcam_idx_t;
    typedef drcam_idx_t drcam_map_t [DRAM_A_W];
    localparam drcam_idx_t NO_BIT = 5'h00;
    localparam int AP_BIT = 10;
    localparam logic [1:0] DENS_128 = 2'h0;
    localparam logic [1:0] DENS_256 = 2'h1;
    localparam logic [1:0] DENS_512 = 2'h2;
    localparam int UNIT_LSB = 26;
    localparam int UNIT_W = 7;
    localparam logic [UNIT_W-1:0] ROW_UNITS [CFG_NUM] = '{7'h01, 7'h02, 7'h02, 7'h04, 7'h04, 7'h08};
    localparam drcam_map_t ROW_MAP [CFG_NUM] = '{
        '{5'h11, 5'h0F, 5'h18, 5'h19, 5'h15, 5'h16, 5'h17, 5'h1B, 5'h1C, 5'h1A, 5'h0E, 5'h10, 5'h00},
        '{5'h11, 5'h0F, 5'h1C, 5'h1D, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h10, 5'h00},
        '{5'h11, 5'h0F, 5'h1C, 5'h1D, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h0E, 5'h10, 5'h1B},
        '{5'h11, 5'h0F, 5'h1D, 5'h1E, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h10, 5'h1C},
        '{5'h11, 5'h0F, 5'h1D, 5'h1E, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h10, 5'h1C},
        '{5'h11, 5'h0F, 5'h18, 5'h19, 5'h15, 5'h16, 5'h17, 5'h1E, 5'h1F, 5'h1A, 5'h1B, 5'h1D, 5'h1C}};
    localparam drcam_map_t COL_MAP [CFG_NUM] = '{
        '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h00, 5'h00, 5'h00, 5'h00},
        '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h00, 5'h00, 5'h00},
        '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h00, 5'h00, 5'h00, 5'h00},
        '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h00, 5'h00, 5'h00},
        '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h00, 5'h00, 5'h00},
        '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h00, 5'h0E, 5'h00}};
    localparam drcam_idx_t BA0_MAP [CFG_NUM] = '{5'h0D, 5'h12, 5'h0D, 5'h12, 5'h12, 5'h0F};
    localparam drcam_idx_t BA1_MAP [CFG_NUM] = '{5'h12, 5'h0E, 5'h12, 5'h0E, 5'h0E, 5'h12};
    localparam int THR_CTRL_W = 64;
    localparam int THR_CNT_W = 16;
    localparam int THR_WIN_LSB = 0;
    localparam int THR_LIMIT_LSB = 16;
    localparam int THR_ALLOW_LSB = 32;
    localparam int THR_EN_BIT = 48;
    localparam int DIR_RD = 0;
    localparam int DIR_WR = 1;
endpackage
`default_nettype wire

// file: drcam_tb_top.sv
/*
 Self-checking bench for drcam_top with models of the row 0 and row 1 maps.
 Assumes the sink model and the checker are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
module drcam_tb_top;
    logic clk = 0, rst = 1, cfg = 0, slow = 1, vld = 0, wr = 0, ap = 0, c_rdy, ok;
    logic [3:0] pop = 4'h1, x16 = 4'h1, cs;
    logic [7:0] dens = 8'h00;
    logic [1:0] frc = 2'h0, bk;
    logic [63:0] rctl = 64'h0, wctl = 64'h0;
    logic [31:0] addr = 32'h0, seed = 32'h1194;
    logic [5:0] lim = 6'h01;
    localparam logic [6:0] SPD_DEV = {4'hA, 3'h0};
    logic rdy, cv, cw, aerr, cerr, rthr, wthr;
    logic [12:0] ra, ca;
    logic [32:0] expq[$];
    int miscompares = 0, n_checks = 0;
    int rmap[12] = '{17, 15, 24, 25, 21, 22, 23, 27, 28, 26, 14, 16};
    int rmap8[13] = '{17, 15, 24, 25, 21, 22, 23, 30, 31, 26, 27, 29, 28};
    initial forever #10 clk = ~clk;
    drcam_top drcam_top_inst (.sys_clk_i(clk), .sys_rst_i(rst), .cfg_done_i(cfg),
        .row_populated_i(pop), .row_density_i(dens), .row_x16_i(x16),
        .sw_force_throttle_i(frc), .rd_throttle_ctrl_i(rctl), .wr_throttle_ctrl_i(wctl),
        .req_valid_i(vld), .req_write_i(wr), .req_auto_precharge_i(ap), .req_addr_i(addr),
        .req_ready_o(rdy), .cmd_ready_i(c_rdy), .cmd_valid_o(cv), .cmd_write_o(cw),
        .cmd_row_cs_o(cs), .cmd_bank_o(bk), .cmd_row_addr_o(ra), .cmd_col_addr_o(ca),
        .addr_error_o(aerr), .config_error_o(cerr), .rd_throttled_o(rthr),
        .wr_throttled_o(wthr));
    drcam_cmd_sink drcam_cmd_sink_inst (.clk_i(clk), .rst_i(rst), .slow_i(slow),
        .cmd_valid_i(cv), .cmd_ready_o(c_rdy));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Presence ROM of the row 0 DIMM; its strap is tied low, so it answers one address only.
    function automatic logic [7:0] spd_rd(input logic [6:0] dev, input int idx);
        if (dev[6:3] != 4'hA || dev[2:0] != 3'h0) return 8'hFF;
        case (idx)
            2: return 8'h07;
            3: return 8'h0C;
            4: return 8'h09;
            5: return 8'h01;
            17: return 8'h04;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [32:0] model(input logic [31:0] a, input logic w, input logic p);
        logic [12:0] r;
        r = 13'h0000;
        if (a[31:26] == 6'h00) begin
            for (int i = 0; i < 12; i++) r[i] = a[rmap[i]];
            return {w, 4'h1, a[18], a[13], r, 2'h0, p, 1'b0, a[12:4]};
        end
        for (int i = 0; i < 13; i++) r[i] = a[rmap8[i]];
        return {w, 4'h2, a[18], a[15], r, 1'b0, a[14], p, a[13:4]};
    endfunction
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic nxt();
        @(posedge clk);
        #1;
    endtask
    // Request is held until an edge with ready; the caller owns valid.
    task automatic req(input logic [31:0] a, input logic w, input logic p);
        int n;
        n = 0;
        wr = w;
        ap = p;
        addr = a;
        do begin
            @(negedge clk);
            ok = rdy;
            @(posedge clk);
            n++;
        end while (!ok && n < 100);
        #1;
        cmp(ok, 1);
        cmp(aerr, a[31:26] >= lim);
        if (a[31:26] < lim) expq.push_back(model(a, w, p));
    endtask
    always @(posedge clk) if (!rst && cv && c_rdy) cmp({cw, cs, bk, ra, ca}, expq.pop_front());
    initial begin
        repeat (8) nxt();
        rst = 0;
        vld = 1;
        @(negedge clk);
        cmp(rdy, 0);
        nxt();
        {dens[1:0], x16[0]} = (spd_rd(SPD_DEV, 2) == 8'h07 && spd_rd(SPD_DEV, 3) == 8'h0C
            && spd_rd(SPD_DEV, 4) == 8'h09) ? 3'h1 : 3'h6;
        cfg = 1;
        for (int i = 0; i < 60; i++) begin
            seed = xs(seed);
            slow = i < 30;
            req(seed[3] ? {6'h00, seed[31:6]} : seed, seed[0], seed[1]);
        end
        vld = 0;
        slow = 0;
        repeat (4) nxt();
        cmp(expq.size(), 0);
        for (int i = 0; i < 8; i++) begin
            nxt();
            dens = {6'h00, i[2:1]};
            x16 = {3'h0, i[0]};
            @(negedge clk);
            cmp(cerr, i[2:1] == 2'h3);
        end
        nxt();
        pop = 4'h3;
        x16 = 4'h2;
        dens = 8'h00;
        @(negedge clk);
        cmp(cerr, 1);
        nxt();
        pop = 4'h1;
        x16 = 4'h1;
        addr = 32'hFC00_0000;
        for (int d = 0; d < 2; d++) begin
            nxt();
            frc = 2'h1 << d;
            wr = d[0];
            vld = 1;
            @(negedge clk);
            cmp({rthr, wthr, rdy}, {d == 0, d == 1, 1'b0});
            nxt();
            wr = !d[0];
            @(negedge clk);
            cmp(rdy, 1);
            nxt();
            vld = 0;
            frc = 2'h0;
        end
        nxt();
        rctl = {15'h0, 1'b1, 16'h0001, 16'h0001, 16'h0007};
        vld = 1;
        // Eight reads fill the first eight-cycle window and trip the counter;
        // from then on only one read per window is let through.
        for (int i = 0; i < 12; i++) begin
            req(32'h0000_1000 * i, 0, 0);
            cmp(rdy, i < 8);
        end
        vld = 0;
        @(negedge clk);
        cmp({rthr, wthr}, 2'h2);
        nxt();
        pop = 4'h3;
        dens = 8'h08;
        lim = 6'h09;
        vld = 1;
        // Row 1 stacks eight units above row 0; units 9 and up hit no row.
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            req({2'h0, seed[31:28], seed[25:0]}, 1, seed[26]);
        end
        vld = 0;
        repeat (4) nxt();
        cmp(expq.size(), 0);
        summarize();
    end
    initial begin
        #200000;
        miscompares++;
        summarize();
    end
endmodule
`default_nettype wire

// file: drcam_thr_if.sv
/*
 Carrier between the address map top and one throttle engine.
 Assumes both ends share the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface drcam_thr_if;
    logic access;
    logic force_on;
    logic [drcam_pkg::THR_CTRL_W-1:0] ctrl;
    logic allow;
    logic throttled;
    modport engine (input access, input force_on, input ctrl, output allow, output throttled);
    modport client (output access, output force_on, output ctrl, input allow, input throttled);
endinterface
`default_nettype wire

// file: drcam_throttle.sv
/*
 One thermal throttle engine: counts accesses per window and limits them.
 Assumes access is a one-cycle pulse per issued access.
*/
`timescale 1ns/100ps
`default_nettype none
module drcam_throttle (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    drcam_thr_if.engine thr
);
    logic [drcam_pkg::THR_CNT_W-1:0] win_reg;
    logic [drcam_pkg::THR_CNT_W-1:0] cnt_reg;
    logic trip_reg;
    logic win_end;
    logic [drcam_pkg::THR_CNT_W-1:0] win_len;
    logic [drcam_pkg::THR_CNT_W-1:0] limit;
    logic [drcam_pkg::THR_CNT_W-1:0] allow_max;

    assign win_len = thr.ctrl[drcam_pkg::THR_WIN_LSB +: drcam_pkg::THR_CNT_W];
    assign limit = thr.ctrl[drcam_pkg::THR_LIMIT_LSB +: drcam_pkg::THR_CNT_W];
    assign allow_max = thr.ctrl[drcam_pkg::THR_ALLOW_LSB +: drcam_pkg::THR_CNT_W];
    assign win_end = (win_reg == '0);

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            win_reg <= '0;
        end else if (win_end) begin
            win_reg <= win_len;
        end else begin
            win_reg <= win_reg - 1'b1;
        end
    end

    // The count saturates so a long window cannot wrap into a low figure.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_reg <= '0;
        end else if (win_end) begin
            cnt_reg <= {{(drcam_pkg::THR_CNT_W-1){1'b0}}, thr.access};
        end else if (thr.access && cnt_reg != '1) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            trip_reg <= 1'b0;
        end else if (win_end) begin
            trip_reg <= thr.ctrl[drcam_pkg::THR_EN_BIT] && (cnt_reg >= limit); // RULE11
        end
    end

    assign thr.throttled = thr.force_on || trip_reg; // RULE11
    assign thr.allow = !thr.throttled || (cnt_reg < allow_max); // RULE9
endmodule
`default_nettype wire

// file: drcam_top.sv
/*
 Host address to row, bank and column translation for dual discrete
 dynamic mode, row configuration checks and read/write thermal throttling.
 Assumes software has sized memory from the presence ROMs and drives the
 configuration inputs before raising cfg_done_i; inputs are synchronous.
*/
`timescale 1ns/100ps
`default_nettype none
module drcam_top (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic cfg_done_i,
    input wire logic [3:0] row_populated_i,
    input wire logic [7:0] row_density_i,
    input wire logic [3:0] row_x16_i,
    input wire logic [1:0] sw_force_throttle_i,
    input wire logic [63:0] rd_throttle_ctrl_i,
    input wire logic [63:0] wr_throttle_ctrl_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic req_auto_precharge_i,
    input wire logic [31:0] req_addr_i,
    output logic req_ready_o,
    input wire logic cmd_ready_i,
    output logic cmd_valid_o,
    output logic cmd_write_o,
    output logic [3:0] cmd_row_cs_o,
    output logic [1:0] cmd_bank_o,
    output logic [12:0] cmd_row_addr_o,
    output logic [12:0] cmd_col_addr_o,
    output logic addr_error_o,
    output logic config_error_o,
    output logic rd_throttled_o,
    output logic wr_throttled_o
);
    typedef logic [2:0] drcam_cfg_t;

    drcam_thr_if rd_thr ();
    drcam_thr_if wr_thr ();

    drcam_cfg_t row_cfg [drcam_pkg::NUM_ROWS];
    logic [drcam_pkg::NUM_ROWS-1:0] row_ok;
    logic [drcam_pkg::UNIT_W-1:0] row_end [drcam_pkg::NUM_ROWS];
    logic [drcam_pkg::NUM_ROWS-1:0] hit;
    logic [1:0] sel_row;
    logic sel_found;
    drcam_cfg_t sel_cfg;
    logic [drcam_pkg::UNIT_W-1:0] addr_unit;
    logic dir_allow;
    logic out_free;
    logic take;
    logic cmd_valid_reg;
    logic cmd_write_reg;
    logic [3:0] cs_reg;
    logic [1:0] bank_reg;
    logic [12:0] row_addr_reg;
    logic [12:0] col_addr_reg;
    logic addr_err_reg;

    function automatic logic [12:0] pick_bits(input logic [31:0] addr,
                                              input drcam_pkg::drcam_map_t idx);
        logic [12:0] res;
        res = '0;
        for (int i = 0; i < drcam_pkg::DRAM_A_W; i++) begin
            res[i] = (idx[i] == drcam_pkg::NO_BIT) ? 1'b0 : addr[idx[i]];
        end
        return res;
    endfunction

    // Width and density select one of six layouts, x16 first in each density.
    function automatic drcam_cfg_t cfg_code(input logic [1:0] dens, input logic x16);
        return drcam_cfg_t'({dens, ~x16});
    endfunction

    // Rows are only checked against what software wrote; nothing here probes
    // the DIMMs, so a wrong setting is caught only if it is an illegal one.
    always_comb begin
        for (int r = 0; r < drcam_pkg::NUM_ROWS; r++) begin
            row_cfg[r] = cfg_code(row_density_i[2*r +: 2], row_x16_i[r]); // RULE5
            row_ok[r] = row_populated_i[r]
                && (row_density_i[2*r +: 2] <= drcam_pkg::DENS_512) // RULE3
                && !(row_x16_i[r] && r[0]); // RULE4
        end
    end

    assign config_error_o = |(row_populated_i & ~row_ok); // RULE4

    // Rows stack upward from zero in chip-select order.
    always_comb begin
        for (int r = 0; r < drcam_pkg::NUM_ROWS; r++) begin
            row_end[r] = (r == 0) ? '0 : row_end[(r == 0) ? 0 : r-1];
            if (row_ok[r]) begin
                row_end[r] = row_end[r] + drcam_pkg::ROW_UNITS[row_cfg[r]]; // RULE2
            end
        end
    end

    assign addr_unit = {1'b0, req_addr_i[drcam_pkg::UNIT_LSB +: (drcam_pkg::UNIT_W-1)]};

    always_comb begin
        sel_row = '0;
        sel_found = 1'b0;
        for (int r = drcam_pkg::NUM_ROWS-1; r >= 0; r--) begin
            hit[r] = row_ok[r] && (addr_unit < row_end[r]);
            if (hit[r]) begin
                sel_row = r[1:0]; // RULE2
                sel_found = 1'b1;
            end
        end
    end

    assign sel_cfg = row_cfg[sel_row]; // RULE12

    assign rd_thr.access = take && !req_write_i;
    assign wr_thr.access = take && req_write_i;
    assign rd_thr.force_on = sw_force_throttle_i[drcam_pkg::DIR_RD]; // RULE11
    assign wr_thr.force_on = sw_force_throttle_i[drcam_pkg::DIR_WR]; // RULE11
    assign rd_thr.ctrl = rd_throttle_ctrl_i; // RULE10
    assign wr_thr.ctrl = wr_throttle_ctrl_i; // RULE10

    drcam_throttle u_rd_throttle (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .thr(rd_thr.engine)
    );

    drcam_throttle u_wr_throttle (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .thr(wr_thr.engine)
    );

    // A write stalled by its throttle does not hold up the read path.
    assign dir_allow = req_write_i ? wr_thr.allow : rd_thr.allow; // RULE10
    assign out_free = !cmd_valid_reg || cmd_ready_i;
    assign req_ready_o = cfg_done_i && out_free && dir_allow; // RULE6
    assign take = req_valid_i && req_ready_o;

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmd_valid_reg <= 1'b0;
        end else if (take) begin
            cmd_valid_reg <= sel_found;
        end else if (cmd_ready_i) begin
            cmd_valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmd_write_reg <= 1'b0;
            cs_reg <= '0;
            bank_reg <= '0;
            row_addr_reg <= '0;
            col_addr_reg <= '0;
        end else if (take && sel_found) begin
            cmd_write_reg <= req_write_i;
            cs_reg <= 4'h1 << sel_row; // RULE2
            bank_reg[0] <= req_addr_i[drcam_pkg::BA0_MAP[sel_cfg]]; // RULE1
            bank_reg[1] <= req_addr_i[drcam_pkg::BA1_MAP[sel_cfg]]; // RULE1
            row_addr_reg <= pick_bits(req_addr_i, drcam_pkg::ROW_MAP[sel_cfg]); // RULE1
            col_addr_reg <= pick_bits(req_addr_i, drcam_pkg::COL_MAP[sel_cfg])
                | (13'(req_auto_precharge_i) << drcam_pkg::AP_BIT); // RULE1
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            addr_err_reg <= 1'b0;
        end else begin
            addr_err_reg <= take && !sel_found;
        end
    end

    assign cmd_valid_o = cmd_valid_reg;
    assign cmd_write_o = cmd_write_reg;
    assign cmd_row_cs_o = cs_reg;
    assign cmd_bank_o = bank_reg;
    assign cmd_row_addr_o = row_addr_reg;
    assign cmd_col_addr_o = col_addr_reg;
    assign addr_error_o = addr_err_reg;
    assign rd_throttled_o = rd_thr.throttled; // RULE9
    assign wr_throttled_o = wr_thr.throttled; // RULE9
endmodule
`default_nettype wire
